// >>> core/otd_pkg.sv
// otd_pkg: register map, field positions and reset values of the
// over-temperature output and remote diode fault block.
// assumes: imported nowhere, every use written otd_pkg::name.
package otd_pkg;

    // register offsets on the byte-wide register port
    localparam logic [7:0] ADDR_REMOTE_HI   = 8'h01;
    localparam logic [7:0] ADDR_STATUS      = 8'h02;
    localparam logic [7:0] ADDR_CONFIG      = 8'h03;
    localparam logic [7:0] ADDR_CONV_RATE   = 8'h0a;
    localparam logic [7:0] ADDR_REMOTE_LO   = 8'h10;
    localparam logic [7:0] ADDR_LIMIT_LOCAL = 8'h19;
    localparam logic [7:0] ADDR_LIMIT_REM   = 8'h20;
    localparam logic [7:0] ADDR_HYST        = 8'h21;

    // field positions
    localparam int CFG_MASK_BIT     = 7;
    localparam int STS_OT_LOCAL     = 0;
    localparam int STS_OT_REMOTE    = 1;
    localparam int STS_REMOTE_OPEN  = 2;
    localparam int STS_REMOTE_LOW   = 3;

    // channel indices
    localparam int CH_LOCAL  = 0;
    localparam int CH_REMOTE = 1;
    localparam int NUM_CH    = 2;

    // reset values
    localparam logic [7:0] RST_CONFIG    = 8'h00;
    localparam logic [7:0] RST_CONV_RATE = 8'h08;
    localparam logic [7:0] RST_LIMIT     = 8'h55;
    localparam logic [7:0] RST_HYST      = 8'h0a;
    localparam logic [7:0] RST_TEMP      = 8'h00;

    // forced readings on diode faults
    localparam logic [7:0] SHORT_HI = 8'hc0;
    localparam logic [7:0] SHORT_LO = 8'h00;
    localparam logic [7:0] OPEN_HI  = 8'h00;
    localparam logic [7:0] OPEN_LO  = 8'h00;

    // low byte keeps its fraction in the top bits only
    localparam logic [7:0] LO_FRAC_MASK = 8'he0;

endpackage

// >>> core/otd_sync.sv
// otd_sync: two-flop synchroniser for a vector of independent levels.
// assumes: each bit is a slow level; no bit relation kept across bits.
`timescale 1ns/1ps
`default_nettype none
module otd_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    // levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule
`default_nettype wire

// >>> core/otd_core.sv
// otd_core: over-temperature output, diode fault handling and the
// register file behind the byte-wide register port.
// assumes: conversion results and conv_done_i come from same-clock
// logic; the diode fault comparators are asynchronous levels.
//
// Summary of operation
// RQ1 - drive overtemp output low when any channel exceeds its limit.
// RQ2 - hold output low until all channels drop below limit minus hysteresis.
// RQ3 - overtemp status bits set while output asserted, cleared on release.
// RQ4 - check remote diode for open or short on every conversion.
// RQ5 - on remote short assert alarm output unless mask bit set.
// RQ6 - on remote short report high byte 0xc0 and low byte 0x00.
// RQ7 - on remote short set the remote low-limit flag.
// RQ8 - open before first valid conversion reads zero degrees, sets open flag.
// RQ9 - open after that keeps the previous converted remote result.
// RQ10 - reset from supply monitor clears all volatile registers.
// RQ11 - host should run four conversions per second and average them.
// RQ12 - host should moving-average the last four per-second averages.
// RQ13 - config bit seven masks the alarm output; zero lets it assert.
// RQ14 - status register read releases the latched alarm output.
// RQ15 - comparisons and fault checks run once per finished conversion.
`timescale 1ns/1ps
`default_nettype none
module otd_core (
    // clock and reset (reset is the supply monitor output)
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // conversion results
    input  wire logic       conv_done_i,
    input  wire logic [7:0] local_temp_i,
    input  wire logic [7:0] remote_hi_i,
    input  wire logic [7:0] remote_lo_i,
    // remote diode fault comparators (asynchronous)
    input  wire logic       diode_open_i,
    input  wire logic       diode_short_i,
    // register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // open-drain outputs
    output logic            overtemp_output_o,
    output logic            overtemp_output_oe_o,
    output logic            alarm_o,
    output logic            alarm_oe_o
);

    logic [1:0] fault_sync;
    logic       open_s;
    logic       short_s;

    // registers
    logic [7:0] config_ff;
    logic [7:0] conv_rate_ff;
    logic [7:0] limit_ff [otd_pkg::NUM_CH];
    logic [7:0] hyst_ff;
    logic [7:0] rem_hi_ff;
    logic [7:0] rem_lo_ff;
    logic [7:0] local_ff;
    logic       seen_valid_ff;
    logic       overtemp_output_ff;
    logic [otd_pkg::NUM_CH-1:0] ot_sts_ff;
    logic       open_flag_ff;
    logic       low_flag_ff;
    logic       alarm_ff;
    logic [7:0] rdata_ff;

    logic [7:0] nxt_rem_hi;
    logic [7:0] nxt_rem_lo;
    logic       nxt_overtemp_output;
    logic [otd_pkg::NUM_CH-1:0] nxt_ot_sts;
    logic       nxt_open_flag;
    logic       nxt_low_flag;
    logic       nxt_alarm;

    otd_sync #(
        .W(2)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i    (rst_i),
        .async_i  ({diode_short_i, diode_open_i}),
        .sync_o   (fault_sync)
    );
    assign open_s  = fault_sync[0];
    assign short_s = fault_sync[1];

    // register decode
    wire wr_cfg   = reg_wr_i && (reg_addr_i == otd_pkg::ADDR_CONFIG);
    wire wr_rate  = reg_wr_i && (reg_addr_i == otd_pkg::ADDR_CONV_RATE);
    wire wr_lim0  = reg_wr_i && (reg_addr_i == otd_pkg::ADDR_LIMIT_LOCAL);
    wire wr_lim1  = reg_wr_i && (reg_addr_i == otd_pkg::ADDR_LIMIT_REM);
    wire wr_hyst  = reg_wr_i && (reg_addr_i == otd_pkg::ADDR_HYST);
    wire rd_sts   = reg_rd_i && (reg_addr_i == otd_pkg::ADDR_STATUS);
    wire mask_on  = config_ff[otd_pkg::CFG_MASK_BIT];

    // remote result with fault overrides, checked on each conversion
    wire do_short = conv_done_i && short_s;                       // [RQ4]
    wire do_open  = conv_done_i && open_s && !short_s;            // [RQ4]
    assign nxt_rem_hi =
        do_short ? otd_pkg::SHORT_HI :                            // [RQ6]
        (do_open && !seen_valid_ff) ? otd_pkg::OPEN_HI :          // [RQ8]
        do_open ? rem_hi_ff :                                     // [RQ9]
        conv_done_i ? remote_hi_i : rem_hi_ff;
    assign nxt_rem_lo =
        do_short ? otd_pkg::SHORT_LO :                            // [RQ6]
        (do_open && !seen_valid_ff) ? otd_pkg::OPEN_LO :          // [RQ8]
        do_open ? rem_lo_ff :                                     // [RQ9]
        conv_done_i ? (remote_lo_i & otd_pkg::LO_FRAC_MASK)
                    : rem_lo_ff;

    // fresh channel values used for the comparison
    wire [7:0] ch_val [otd_pkg::NUM_CH];
    assign ch_val[otd_pkg::CH_LOCAL]  = conv_done_i ? local_temp_i
                                                    : local_ff;
    assign ch_val[otd_pkg::CH_REMOTE] = nxt_rem_hi;               // [RQ15]

    logic [otd_pkg::NUM_CH-1:0] over;
    logic [otd_pkg::NUM_CH-1:0] below;
    genvar g;
    generate
        for (g = 0; g < otd_pkg::NUM_CH; g++) begin : g_ch
            // nine bits so limit minus hysteresis wraps only below -256
            wire signed [8:0] t9 = {ch_val[g][7], ch_val[g]};
            wire signed [8:0] l9 = {limit_ff[g][7], limit_ff[g]};
            wire signed [8:0] h9 = {1'b0, hyst_ff};
            wire signed [8:0] rel9 = 9'(l9 - h9);
            assign over[g]  = (t9 > l9);                          // [RQ1]
            assign below[g] = (t9 < rel9);                        // [RQ2]
        end
    endgenerate

    // output sets on any excess, releases only once all are below
    assign nxt_overtemp_output = !conv_done_i ? overtemp_output_ff :                  // [RQ15]
                       (|over) ? 1'b1 :                           // [RQ1]
                       (&below) ? 1'b0 : overtemp_output_ff;                // [RQ2]
    // status bits follow each excess and drop only with the output
    assign nxt_ot_sts = !nxt_overtemp_output ? '0 :
                        (ot_sts_ff | (conv_done_i ? over : '0));  // [RQ3]

    // sticky fault flags: a new event wins over the read-clear
    assign nxt_open_flag = do_open || (open_flag_ff && !rd_sts);  // [RQ8]
    assign nxt_low_flag  = do_short || (low_flag_ff && !rd_sts);  // [RQ7]
    // alarm latches on short, freed by mask or status read
    assign nxt_alarm = (do_short && !mask_on) ||                  // [RQ5]
                       (alarm_ff && !mask_on && !rd_sts);         // [RQ13] [RQ14]

    wire [7:0] sts_word = {4'h0, low_flag_ff, open_flag_ff,
                           ot_sts_ff[otd_pkg::CH_REMOTE],
                           ot_sts_ff[otd_pkg::CH_LOCAL]};
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            otd_pkg::ADDR_REMOTE_HI:   rd_mux = rem_hi_ff;
            otd_pkg::ADDR_STATUS:      rd_mux = sts_word;
            otd_pkg::ADDR_CONFIG:      rd_mux = config_ff;
            otd_pkg::ADDR_CONV_RATE:   rd_mux = conv_rate_ff;
            otd_pkg::ADDR_REMOTE_LO:   rd_mux = rem_lo_ff;
            otd_pkg::ADDR_LIMIT_LOCAL: rd_mux = limit_ff[otd_pkg::CH_LOCAL];
            otd_pkg::ADDR_LIMIT_REM:   rd_mux = limit_ff[otd_pkg::CH_REMOTE];
            otd_pkg::ADDR_HYST:        rd_mux = hyst_ff;
            default:                   rd_mux = 8'h00;
        endcase
    end

    // every volatile register returns to its reset value
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin                                          // [RQ10]
            config_ff     <= otd_pkg::RST_CONFIG;
            conv_rate_ff  <= otd_pkg::RST_CONV_RATE;
            limit_ff[otd_pkg::CH_LOCAL]  <= otd_pkg::RST_LIMIT;
            limit_ff[otd_pkg::CH_REMOTE] <= otd_pkg::RST_LIMIT;
            hyst_ff       <= otd_pkg::RST_HYST;
        end else begin
            if (wr_cfg)  config_ff    <= reg_wdata_i;             // [RQ13]
            if (wr_rate) conv_rate_ff <= reg_wdata_i;
            if (wr_lim0) limit_ff[otd_pkg::CH_LOCAL]  <= reg_wdata_i;
            if (wr_lim1) limit_ff[otd_pkg::CH_REMOTE] <= reg_wdata_i;
            if (wr_hyst) hyst_ff      <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin                                          // [RQ10]
            rem_hi_ff     <= otd_pkg::RST_TEMP;
            rem_lo_ff     <= otd_pkg::RST_TEMP;
            local_ff      <= otd_pkg::RST_TEMP;
            seen_valid_ff <= 1'b0;
            overtemp_output_ff      <= 1'b0;
            ot_sts_ff     <= '0;
            open_flag_ff  <= 1'b0;
            low_flag_ff   <= 1'b0;
            alarm_ff      <= 1'b0;
            rdata_ff      <= 8'h00;
        end else begin
            rem_hi_ff     <= nxt_rem_hi;
            rem_lo_ff     <= nxt_rem_lo;
            local_ff      <= ch_val[otd_pkg::CH_LOCAL];
            seen_valid_ff <= seen_valid_ff ||
                             (conv_done_i && !open_s && !short_s);
            overtemp_output_ff      <= nxt_overtemp_output;
            ot_sts_ff     <= nxt_ot_sts;
            open_flag_ff  <= nxt_open_flag;
            low_flag_ff   <= nxt_low_flag;
            alarm_ff      <= nxt_alarm;
            if (reg_rd_i) rdata_ff <= rd_mux;
        end
    end

    // open drain: level is always low, enable carries the state
    assign overtemp_output_o    = 1'b0;
    assign overtemp_output_oe_o = overtemp_output_ff;                       // [RQ1]
    assign alarm_o              = 1'b0;
    assign alarm_oe_o           = alarm_ff;                       // [RQ5]
    assign reg_rdata_o          = rdata_ff;

endmodule
`default_nettype wire

// >>> verif/otd_diode_model.sv
// otd_diode_model: remote junction as seen by the converter.
// assumes: bench holds the mode steady for several clocks.
`timescale 1ns/1ps
`default_nettype none
module otd_diode_model (
    // clock
    input  wire logic       ref_clk_i,
    // junction: 0 good, 1 open, 2 short
    input  wire logic [1:0] mode_i,
    input  wire logic [7:0] temp_i,
    // converter view
    output logic            open_o,
    output logic            short_o,
    output logic      [7:0] remote_hi_o
);
    logic [7:0] junk_ff;
    always @(posedge ref_clk_i) begin
        junk_ff <= (junk_ff === 8'h5a) ? 8'ha6 : 8'h5a;
    end
    assign open_o = mode_i == 2'h1;
    assign short_o = mode_i == 2'h2;
    // broken junction: no stable result reaches the converter
    assign remote_hi_o = (mode_i == 2'h0) ? temp_i : junk_ff;
endmodule
`default_nettype wire

// >>> verif/otd_core_assertions.sv
// otd_core_assertions: port checks of the overtemp and alarm pins.
// assumes: bound to otd_core; shadows local limit and alarm mask.
`timescale 1ns/1ps
`default_nettype none
module otd_core_assertions (
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    // watched ports
    input wire logic       conv_done_i,
    input wire logic [7:0] local_temp_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       overtemp_output_oe_o,
    input wire logic       alarm_oe_o
);
    logic [7:0] lim_ff;
    logic       mask_ff;
    wire        wr_lim = reg_wr_i && reg_addr_i == otd_pkg::ADDR_LIMIT_LOCAL;
    wire        wr_cfg = reg_wr_i && reg_addr_i == otd_pkg::ADDR_CONFIG;
    wire        rd_sts = reg_rd_i && reg_addr_i == otd_pkg::ADDR_STATUS;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lim_ff <= otd_pkg::RST_LIMIT;
            mask_ff <= 1'b0;
        end else begin
            if (wr_lim) lim_ff <= reg_wdata_i;
            if (wr_cfg) mask_ff <= reg_wdata_i[otd_pkg::CFG_MASK_BIT];
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    rst_quiet_a: assert property (
        $fell(rst_i) |-> !overtemp_output_oe_o && !alarm_oe_o)
        else $error("output active after reset");
    ot_set_a: assert property (
        conv_done_i && $signed(local_temp_i) > $signed(lim_ff)
        |=> overtemp_output_oe_o) else $error("overtemp not asserted");
    ot_rise_a: assert property (
        $rose(overtemp_output_oe_o) |-> $past(conv_done_i))
        else $error("overtemp rose without conversion");
    ot_hold_a: assert property (
        $fell(overtemp_output_oe_o) |-> $past(conv_done_i))
        else $error("overtemp released without conversion");
    ot_sts_a: assert property (
        rd_sts && overtemp_output_oe_o && !conv_done_i
        |=> |reg_rdata_o[1:0]) else $error("overtemp status clear");
    alm_rise_a: assert property (
        $rose(alarm_oe_o) |-> $past(conv_done_i) && !$past(mask_ff))
        else $error("alarm rose without cause");
    alm_mask_a: assert property (
        mask_ff |-> ##1 !alarm_oe_o) else $error("masked alarm active");
    sts_rel_a: assert property (
        rd_sts && !conv_done_i |=> !alarm_oe_o)
        else $error("alarm kept after status read");
endmodule
bind otd_core otd_core_assertions u_chk (.ref_clk_i, .rst_i, .conv_done_i,
    .local_temp_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .overtemp_output_oe_o, .alarm_oe_o);
`default_nettype wire

// >>> verif/tb_overtemp_output_and_diode_fault.sv
// tb_overtemp_output_and_diode_fault: self-checking bench of otd_core.
// assumes: design, diode model and checker compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb_overtemp_output_and_diode_fault;
    logic       ref_clk_i = 0, rst_i = 1, conv_done_i = 0, rd_q = 0;
    logic       reg_wr_i = 0, reg_rd_i = 0, d_open, d_short, ot_oe, al_oe;
    logic [7:0] local_temp_i = 0, remote_lo_i = 0, reg_addr_i = 0, e, t;
    logic [7:0] reg_wdata_i = 0, temp = 0, hi, reg_rdata_o, lo, expq[$];
    logic [1:0] mode = 0;
    logic       ot_lvl, al_lvl;
    int         n_mismatch = 0, tests_run = 0, cyc = 0, seed = 9761;
    // rate code for four conversions a second, value assumed
    localparam logic [7:0] RATE_4HZ = 8'h06;
    const logic [7:0] ra[9] = '{8'h01, 8'h02, 8'h03, 8'h0a, 8'h10, 8'h19,
        8'h20, 8'h21, 8'hff};
    const logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h55,
        8'h55, 8'h0a, 8'h00};
    otd_diode_model MODEL (.ref_clk_i, .mode_i(mode), .temp_i(temp),
        .open_o(d_open), .short_o(d_short), .remote_hi_o(hi));
    otd_core DUT (.ref_clk_i, .rst_i, .conv_done_i, .local_temp_i,
        .remote_hi_i(hi), .remote_lo_i, .diode_open_i(d_open),
        .diode_short_i(d_short), .reg_addr_i, .reg_wr_i, .reg_rd_i,
        .reg_wdata_i, .reg_rdata_o, .overtemp_output_o(ot_lvl),
        .overtemp_output_oe_o(ot_oe), .alarm_o(al_lvl), .alarm_oe_o(al_oe));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        expq.push_back(x);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask
    // mode set well ahead so the fault synchroniser has settled
    task automatic cv(input logic [1:0] m, input logic [7:0] l,
                      input logic [7:0] r, input logic [7:0] f);
        @(posedge ref_clk_i);
        mode <= m;
        repeat (3) @(posedge ref_clk_i);
        conv_done_i <= 1'b1;
        local_temp_i <= l;
        temp <= r;
        remote_lo_i <= f;
        @(posedge ref_clk_i);
        conv_done_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask
    always @(posedge ref_clk_i) begin
        rd_q <= reg_rd_i;
        cyc <= cyc + 1;
        if (rd_q) begin
            e = expq.pop_front();
            `CHK(reg_rdata_o, e)
        end
        if (cyc == 6000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
        cv(2'h1, 8'h20, 8'h30, 8'h40);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h04);
        rd(8'h02, 8'h00);
        for (int i = 0; i < 4; i++) begin
            t = 8'($random(seed)) & 8'h3f;
            lo = 8'($random(seed));
            cv(2'h0, 8'h10, t, lo);
            rd(8'h01, t);
            rd(8'h10, lo & 8'he0);
        end
        cv(2'h1, 8'h10, 8'h33, 8'h00);
        rd(8'h01, t);
        rd(8'h10, lo & 8'he0);
        rd(8'h02, 8'h04);
        cv(2'h2, 8'h10, 8'h20, 8'h20);
        `CHK(al_oe, 1'b1)
        `CHK(al_lvl, 1'b0)
        rd(8'h01, 8'hc0);
        rd(8'h10, 8'h00);
        rd(8'h02, 8'h08);
        `CHK(al_oe, 1'b0)
        wr(8'h03, 8'h80);
        rd(8'h03, 8'h80);
        cv(2'h2, 8'h10, 8'h20, 8'h00);
        `CHK(al_oe, 1'b0)
        wr(8'h03, 8'h00);
        cv(2'h2, 8'h10, 8'h20, 8'h00);
        `CHK(al_oe, 1'b1)
        wr(8'h03, 8'h80);
        `CHK(al_oe, 1'b0)
        rd(8'h02, 8'h08);
        cv(2'h0, 8'h60, 8'h10, 8'h00);
        `CHK(ot_oe, 1'b1)
        `CHK(ot_lvl, 1'b0)
        rd(8'h02, 8'h01);
        cv(2'h0, 8'h4b, 8'h10, 8'h00);
        `CHK(ot_oe, 1'b1)
        rd(8'h02, 8'h01);
        cv(2'h0, 8'h4a, 8'h10, 8'h00);
        `CHK(ot_oe, 1'b0)
        rd(8'h02, 8'h00);
        wr(8'h20, 8'h30);
        wr(8'h21, 8'h05);
        wr(8'h0a, RATE_4HZ);
        rd(8'h0a, RATE_4HZ);
        cv(2'h0, 8'h10, 8'h31, 8'h00);
        rd(8'h02, 8'h02);
        cv(2'h0, 8'h10, 8'h2b, 8'h00);
        `CHK(ot_oe, 1'b1)
        cv(2'h0, 8'h10, 8'h2a, 8'h00);
        `CHK(ot_oe, 1'b0)
        cv(2'h0, 8'h60, 8'h10, 8'h00);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        `CHK(ot_oe, 1'b0)
        rd(8'h20, 8'h55);
        rd(8'h21, 8'h0a);
        repeat (2) @(posedge ref_clk_i);
        wrap_up();
    end
endmodule
`default_nettype wire
